// ==== pkg/fault_chk_cfg.svh ====
// constants for the cycle configuration fault checker
// Summary of operation
// - gear not 1:1 at 250/500us: fault 93.4
// - homing mode at 250/500us: fault 93.4
// - rx mapping over 20 bytes at 250us
// - rx mapping of zero bytes: fault 93.4
// - rx mapping over ten objects: fault 93.4
// - tx mapping over eleven objects: fault 93.4
// - clear with safety input off: fault 99.0
// - 99.0 needs pending 30.0 and rise in window
// - self-diagnosis failure: 99.0, power cycle only
// - gear outside 1/1000..1000: fault 93.0
`ifndef FAULT_CHK_CFG_SVH
`define FAULT_CHK_CFG_SVH
`define ADDR_GEAR_NUM      4'h0
`define ADDR_GEAR_DEN      4'h1
`define ADDR_CYCLE         4'h2
`define ADDR_MODE          4'h3
`define ADDR_RX_MAP        4'h4
`define ADDR_TX_MAP        4'h5
`define ADDR_CTRL          4'h6
`define ADDR_FAULT         4'h7
`define CYCLE_250_US       16'd250
`define CYCLE_500_US       16'd500
`define MODE_HOMING        8'h06
`define RX_MAX_BYTES_250   8'd20
`define RX_MAX_OBJS        8'd10
`define TX_MAX_OBJS        8'd11
`define GEAR_RATIO_LIMIT   32'd1000
`define MAIN_SETTING       8'h93
`define SUB_GEAR_RANGE     8'h00
`define SUB_FUNCTION       8'h04
`define MAIN_OTHER         8'h99
`define SUB_OTHER          8'h00
`define MAIN_SAFETY        8'h30
`define SUB_SAFETY         8'h00
`define CLEAR_WINDOW_CYC   8'd16
`define CTRL_CLEAR_BIT     0
`endif

// ==== pkg/fault_chk_pkg.sv ====
// types for the cycle configuration fault checker
package fault_chk_pkg;
	typedef enum logic [1:0] {
		CLR_IDLE   = 2'b00,
		CLR_WINDOW = 2'b01
	} clr_state_t;
endpackage : fault_chk_pkg

// ==== rtl/safety_in_sync.sv ====
// three-flop synchroniser for the two safety inputs
`timescale 1ns/100ps
`default_nettype none
module safety_in_sync (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// raw pins and filtered level
	input  wire logic [1:0] raw_in,
	output logic      [1:0] level
);
	logic [1:0] s1;
	logic [1:0] s2;
	logic [1:0] s3;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			// start at the normal on level so release shows no false rise
			s1 <= 2'h3;
			s2 <= 2'h3;
			s3 <= 2'h3;
		end else begin
			s1 <= raw_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			level <= 2'h3;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (s2[i] == s3[i])
					level[i] <= s3[i];
			end
		end
	end
endmodule : safety_in_sync
`default_nettype wire

// ==== rtl/cycle_config_fault_checker.sv ====
// setting-conflict and generic fault checker for the drive
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "fault_chk_cfg.svh"
module cycle_config_fault_checker
	import fault_chk_pkg::*;
#(
	parameter int WINDOW_CYC = `CLEAR_WINDOW_CYC
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// safety pins and self-diagnosis
	input  wire logic [1:0]  safety_in,
	input  wire logic        self_diag_fail,
	// fault outputs
	output logic             fault_active,
	output logic      [7:0]  fault_main,
	output logic      [7:0]  fault_sub
);
	// settings written by the host
	logic [15:0] gear_num;
	logic [15:0] gear_den;
	logic [15:0] cycle_us;
	logic [7:0]  mode;
	logic [7:0]  rx_bytes;
	logic [7:0]  rx_objs;
	logic [7:0]  tx_objs;

	// safety inputs and clear tracking
	logic [1:0]  safe_lvl;
	logic [1:0]  safe_prev;
	logic        safe_rise;
	logic        diag_lock;
	logic        clr_req;
	logic        safety_pend;
	logic        clr_armed;
	logic [7:0]  win_cnt;
	logic        win_last;
	clr_state_t  clr_state;

	// decoded conditions
	logic        fast_cycle;
	logic        gear_bad;
	logic        gear_not_unity;
	logic        homing_fast;
	logic        rx_too_long;
	logic        rx_empty;
	logic        rx_too_many;
	logic        tx_too_many;
	logic        func_bad;
	logic        both_safe;
	logic        other_held;

	// true when a exceeds b times the ratio limit
	function automatic logic ratio_over(input logic [15:0] a, input logic [15:0] b);
		ratio_over = ({16'h0, a} > (32'(b) * `GEAR_RATIO_LIMIT));
	endfunction : ratio_over

	safety_in_sync u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.raw_in  (safety_in),
		.level   (safe_lvl)
	);

	// register writes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			gear_num <= 16'h0001;
			gear_den <= 16'h0001;
			cycle_us <= 16'h03e8;
			mode     <= 8'h00;
			rx_bytes <= 8'h04;
			rx_objs  <= 8'h01;
			tx_objs  <= 8'h01;
		end else if (reg_wr) begin
			case (reg_addr)
				`ADDR_GEAR_NUM: gear_num <= reg_wdata[15:0];
				`ADDR_GEAR_DEN: gear_den <= reg_wdata[15:0];
				`ADDR_CYCLE:    cycle_us <= reg_wdata[15:0];
				`ADDR_MODE:     mode     <= reg_wdata[7:0];
				`ADDR_RX_MAP: begin
					rx_bytes <= reg_wdata[7:0];
					rx_objs  <= reg_wdata[15:8];
				end
				`ADDR_TX_MAP:   tx_objs  <= reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	assign clr_req = reg_wr && (reg_addr == `ADDR_CTRL) && reg_wdata[`CTRL_CLEAR_BIT];
	assign both_safe = &safe_lvl;
	assign fast_cycle = (cycle_us == `CYCLE_250_US) || (cycle_us == `CYCLE_500_US);
	assign safe_rise = |(safe_lvl & ~safe_prev);
	assign win_last = (win_cnt <= 8'h01);
	assign other_held = fault_active && (fault_main == `MAIN_OTHER);

	// ratio outside 1/1000..1000, zero denominator counted as out of range
	assign gear_bad = (gear_den == 16'h0) || (gear_num == 16'h0)
		|| ratio_over(gear_num, gear_den)
		|| ratio_over(gear_den, gear_num);

	// one term per unsupported combination
	assign gear_not_unity = fast_cycle && (gear_num != gear_den);
	assign homing_fast    = fast_cycle && (mode == `MODE_HOMING);
	assign rx_too_long    = (cycle_us == `CYCLE_250_US) && (rx_bytes > `RX_MAX_BYTES_250);
	assign rx_empty       = (rx_bytes == 8'h00);
	assign rx_too_many    = (rx_objs > `RX_MAX_OBJS);
	assign tx_too_many    = (tx_objs > `TX_MAX_OBJS);
	assign func_bad = gear_not_unity || homing_fast || rx_too_long
		|| rx_empty || rx_too_many || tx_too_many;

	// clear while a safety input is off opens the watch window
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			clr_state <= CLR_IDLE;
			win_cnt   <= 8'h00;
			clr_armed <= 1'b0;
			safe_prev <= 2'h3;
		end else begin
			safe_prev <= safe_lvl;
			clr_armed <= 1'b0;
			case (clr_state)
				CLR_IDLE: begin
					if (clr_req && !both_safe && safety_pend) begin
						clr_state <= CLR_WINDOW;
						win_cnt   <= 8'(WINDOW_CYC);
					end
				end
				CLR_WINDOW: begin
					if (safe_rise) begin
						clr_armed <= 1'b1;
						clr_state <= CLR_IDLE;
					end else if (win_last) begin
						clr_state <= CLR_IDLE;
					end else begin
						win_cnt <= win_cnt - 8'h01;
					end
				end
				default: clr_state <= CLR_IDLE;
			endcase
		end
	end

	// self-diagnosis failure sticks until power cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			diag_lock <= 1'b0;
		else if (self_diag_fail)
			diag_lock <= 1'b1;
	end

	// safety input fault 30.0 pending flag
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			safety_pend <= 1'b0;
		else if (!both_safe)
			safety_pend <= 1'b1;
		else if (clr_req)
			safety_pend <= 1'b0;
	end

	// latched fault code, priority: diag, other, setting, safety
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fault_active <= 1'b0;
			fault_main   <= 8'h00;
			fault_sub    <= 8'h00;
		end else if (diag_lock || self_diag_fail || clr_armed) begin
			fault_active <= 1'b1;
			fault_main   <= `MAIN_OTHER;
			fault_sub    <= `SUB_OTHER;
		end else if (other_held) begin
			// 99.0 leaves only through reset
			fault_active <= 1'b1;
		end else if (gear_bad) begin
			fault_active <= 1'b1;
			fault_main   <= `MAIN_SETTING;
			fault_sub    <= `SUB_GEAR_RANGE;
		end else if (func_bad) begin
			fault_active <= 1'b1;
			fault_main   <= `MAIN_SETTING;
			fault_sub    <= `SUB_FUNCTION;
		end else if (!both_safe && (!fault_active || clr_req)) begin
			// safety off outlasts a clear in the same cycle
			fault_active <= 1'b1;
			fault_main   <= `MAIN_SAFETY;
			fault_sub    <= `SUB_SAFETY;
		end else if (clr_req) begin
			fault_active <= 1'b0;
			fault_main   <= 8'h00;
			fault_sub    <= 8'h00;
		end
	end

	// read data one cycle after strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				`ADDR_GEAR_NUM: reg_rdata <= {16'h0, gear_num};
				`ADDR_GEAR_DEN: reg_rdata <= {16'h0, gear_den};
				`ADDR_CYCLE:    reg_rdata <= {16'h0, cycle_us};
				`ADDR_MODE:     reg_rdata <= {24'h0, mode};
				`ADDR_RX_MAP:   reg_rdata <= {16'h0, rx_objs, rx_bytes};
				`ADDR_TX_MAP:   reg_rdata <= {24'h0, tx_objs};
				`ADDR_CTRL:     reg_rdata <= {29'h0, safe_lvl, diag_lock};
				`ADDR_FAULT:    reg_rdata <= {15'h0, fault_active, fault_main, fault_sub};
				default:        reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end
endmodule : cycle_config_fault_checker
`default_nettype wire

// ==== sim/fault_chk_props.sv ====
// port assertions for the fault checker
`timescale 1ns/100ps
`default_nettype none
module fault_chk_props #(
	parameter int WINDOW_CYC = 16
) (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// register port
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// diagnosis and faults
	input wire logic        self_diag_fail,
	input wire logic        fault_active,
	input wire logic [7:0]  fault_main,
	input wire logic [7:0]  fault_sub
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence stat_rd;
		reg_rd && reg_addr == 4'h7;
	endsequence
	stat_read_a: assert property (stat_rd |=> reg_rdata == {15'h0, $past(fault_active), $past(fault_main),
		$past(fault_sub)}) else $error("status read wrong");
	idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data not zero");
	no_code_a: assert property (!fault_active |-> fault_main == 8'h0 && fault_sub == 8'h0)
		else $error("code without fault");
	known_code_a: assert property (fault_active |-> fault_main inside {8'h93, 8'h99, 8'h30})
		else $error("unknown main code");
	setting_sub_a: assert property (fault_main == 8'h93 |-> fault_sub inside {8'h00, 8'h04})
		else $error("bad setting sub code");
	other_sub_a: assert property (fault_main == 8'h99 |-> fault_sub == 8'h00) else $error("bad sub code");
	diag_set_a: assert property (self_diag_fail |-> ##[1:2] fault_main == 8'h99) else $error("diag not seen");
	diag_hold_a: assert property (fault_main == 8'h99 |=> fault_main == 8'h99) else $error("code 99 lost");
	clear_only_a: assert property ($fell(fault_active) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("fault dropped without write");
endmodule : fault_chk_props
bind cycle_config_fault_checker fault_chk_props #(.WINDOW_CYC(WINDOW_CYC)) fault_chk_props_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .self_diag_fail(self_diag_fail), .fault_active(fault_active),
	.fault_main(fault_main), .fault_sub(fault_sub));
`default_nettype wire

// ==== sim/host_model.sv ====
// host controller model on the register port
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock
	input  wire logic        clk_sys,
	// register port
	output logic      [3:0]  reg_addr,
	output logic      [31:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata
);
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
	task put(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : put
	task get(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask : get
endmodule : host_model
`default_nettype wire

// ==== sim/cycle_config_fault_checker_test.sv ====
// testbench for the fault checker
`timescale 1ns/100ps
`default_nettype none
module cycle_config_fault_checker_test;
	logic        clk_sys, rst_n, reg_wr, reg_rd, self_diag_fail, fault_active;
	logic [1:0]  safety_in;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, got;
	logic [7:0]  fault_main, fault_sub;
	int          mismatches, checks;
	cycle_config_fault_checker #(.WINDOW_CYC(16)) cycle_config_fault_checker_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .safety_in(safety_in), .self_diag_fail(self_diag_fail),
		.fault_active(fault_active), .fault_main(fault_main), .fault_sub(fault_sub));
	host_model host_model_inst (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	task idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : idle
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task stat(input logic [15:0] e);
		host_model_inst.get(4'h7, got);
		cmp("status", {15'h0, e != 16'h0, e}, got);
		cmp("fault pins", {15'h0, e != 16'h0, e}, {15'h0, fault_active, fault_main, fault_sub});
	endtask : stat
	task clr;
		host_model_inst.put(4'h6, 32'h1);
		idle(2);
	endtask : clr
	task chk(input logic [3:0] a, input logic [31:0] bad, input logic [31:0] good, input logic [15:0] e);
		host_model_inst.put(a, bad);
		idle(3);
		stat(e);
		host_model_inst.put(a, good);
		clr;
		stat(16'h0);
	endtask : chk
	task restart;
		rst_n <= 1'b0;
		idle(20);
		rst_n <= 1'b1;
		idle(8);
		clr;
		stat(16'h0);
	endtask : restart
	task cfg_250;
		host_model_inst.put(4'h4, 32'h0208);
		host_model_inst.put(4'h2, 32'd250);
		host_model_inst.get(4'h9, got);
		cmp("unmapped", 32'h0, got);
		chk(4'h0, 32'd2, 32'd1, 16'h9304);
		chk(4'h3, 32'h6, 32'h0, 16'h9304);
		chk(4'h4, 32'h0215, 32'h0208, 16'h9304);
		chk(4'h4, 32'h0200, 32'h0208, 16'h9304);
		chk(4'h5, 32'd12, 32'd1, 16'h9304);
		chk(4'h0, 32'd1001, 32'd1, 16'h9300);
	endtask : cfg_250
	task cfg_other;
		host_model_inst.put(4'h2, 32'd500);
		chk(4'h0, 32'd2, 32'd1, 16'h9304);
		chk(4'h3, 32'h6, 32'h0, 16'h9304);
		chk(4'h4, 32'h0215, 32'h0208, 16'h0);
		host_model_inst.put(4'h2, 32'd1000);
		chk(4'h4, 32'h0b08, 32'h0208, 16'h9304);
		chk(4'h1, 32'd1001, 32'd1, 16'h9300);
	endtask : cfg_other
	task safety_late;
		safety_in <= 2'b10;
		idle(8);
		stat(16'h3000);
		clr;
		idle(30);
		stat(16'h3000);
		safety_in <= 2'b11;
		idle(8);
		stat(16'h3000);
		clr;
		stat(16'h0);
	endtask : safety_late
	task safety_race;
		safety_in <= 2'b01;
		idle(8);
		host_model_inst.put(4'h6, 32'h1);
		safety_in <= 2'b11;
		idle(8);
		stat(16'h9900);
		clr;
		stat(16'h9900);
		restart;
	endtask : safety_race
	task diag;
		self_diag_fail <= 1'b1;
		idle(1);
		self_diag_fail <= 1'b0;
		idle(3);
		stat(16'h9900);
		clr;
		stat(16'h9900);
		host_model_inst.get(4'h6, got);
		cmp("control", 32'h7, got);
		restart;
	endtask : diag
	initial begin
		rst_n = 1'b0;
		safety_in = 2'b11;
		self_diag_fail = 1'b0;
		restart;
		cfg_250;
		cfg_other;
		safety_late;
		safety_race;
		diag;
		close_out;
	end
	initial begin
		idle(20000);
		mismatches++;
		close_out;
	end
endmodule : cycle_config_fault_checker_test
`default_nettype wire
